// file: shared/lseg_pkg.sv
// constants, register map and types for the laser safety enable gating block
//
// Behaviour
// - lasing only while manual gate switch open
// - request plus open switch lights indicator, powers driver
// - lasing needs both switch open and request
// - keyswitch variant waits five seconds before lasing
// - gate status closes when switch open and requested
// - keyswitch lasing only five seconds after status closes
// - driver power needs interlock, ready and gate
// - interlock asserted shows green, allows power
// - interlock removal kills power, red, ready cleared
// - stay disabled until interlock reasserted
// - interlock status closes while interlock circuit open
// - non-keyswitch: ready follows interlock, no delay
// - keyswitch: ready latched off until reset pulse
// - reset or inhibit input forces driver off
package lseg_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned DELAY_S      = 5;
	localparam int unsigned DELAY_CYCLES = CLK_HZ * DELAY_S;
	localparam int unsigned CNT_W        = 32;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_EVENT  = 12'h008;
	localparam logic [11:0] ADDR_MASK   = 12'h00C;

	// ctrl fields
	localparam int unsigned CTRL_SW_INHIBIT = 0;
	localparam int unsigned CTRL_RST_VAL    = 0;

	// status fields
	localparam int unsigned ST_GATE   = 0;
	localparam int unsigned ST_READY  = 1;
	localparam int unsigned ST_INTLK  = 2;
	localparam int unsigned ST_RF     = 3;
	localparam int unsigned ST_DELAY  = 4;
	localparam int unsigned ST_KEYVAR = 5;

	// event bits: 0 interlock fault, 1 rf on, 2 rf off, 3 gate closed
	localparam int unsigned EV_N       = 4;
	localparam int unsigned EV_FAULT   = 0;
	localparam int unsigned EV_RF_ON   = 1;
	localparam int unsigned EV_RF_OFF  = 2;
	localparam int unsigned EV_GATE_DN = 3;

	typedef struct packed {
		logic gate_request;
		logic gate_switch_open;
		logic interlock;
		logic remote_reset;
	} lseg_in_t;

	typedef struct packed {
		logic gate_indicator;
		logic ready_indicator;
		logic interlock_green;
		logic interlock_red;
		logic rf_power_en;
	} lseg_out_t;

	typedef enum logic [1:0] {LSEG_WAIT_RESET, LSEG_ARMED} lseg_ready_t;
endpackage : lseg_pkg

// file: logic/lseg_gating.sv
// safety gating of rf driver power with apb status and interrupt
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module lseg_gating
#(
	parameter bit          KEYSWITCH_VARIANT = 1'b1,
	parameter int unsigned DELAY_CYCLES      = lseg_pkg::DELAY_CYCLES
)
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire lseg_pkg::lseg_in_t    pins_in,
	output lseg_pkg::lseg_out_t        ind,
	output logic                       gate_status_out,
	output logic                       gate_status_oe,
	output logic                       intlk_status_out,
	output logic                       intlk_status_oe,
	output logic                       irq
);
	// ****************************************
	// input synchronisers
	// ****************************************
	lseg_pkg::lseg_in_t sync1;
	lseg_pkg::lseg_in_t sync2;
	lseg_pkg::lseg_in_t pin;
	lseg_pkg::lseg_in_t next_sync1;
	lseg_pkg::lseg_in_t next_sync2;

	always_comb
	begin
		next_sync1 = pins_in;
		next_sync2 = sync1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end
	assign pin = sync2;

	// ****************************************
	// ready latch, delay counter and gating
	// ****************************************
	lseg_pkg::lseg_ready_t   rstate;
	lseg_pkg::lseg_ready_t   next_rstate;
	logic [lseg_pkg::CNT_W-1:0] cnt;
	logic [lseg_pkg::CNT_W-1:0] next_cnt;
	logic                    rst_prev;
	logic                    next_rst_prev;
	logic                    sw_inhibit;
	logic                    gate_ok;
	logic                    ready;
	logic                    inhibit;
	logic                    enable_cond;
	logic                    delay_done;
	logic                    rf_on;
	logic                    rf_prev;
	logic                    gate_prev;
	logic [lseg_pkg::CNT_W-1:0] term;

	assign term    = lseg_pkg::CNT_W'(DELAY_CYCLES);
	assign inhibit = pin.remote_reset | sw_inhibit;
	assign gate_ok = pin.gate_switch_open & pin.gate_request;

	always_comb
	begin
		next_rstate   = rstate;
		next_rst_prev = pin.remote_reset;
		case (rstate)
			lseg_pkg::LSEG_WAIT_RESET:
				// keyswitch units arm on release of the reset pulse
				if (!KEYSWITCH_VARIANT)
					next_rstate = lseg_pkg::LSEG_ARMED;
				else if (rst_prev && !pin.remote_reset && pin.interlock)
					next_rstate = lseg_pkg::LSEG_ARMED;
			lseg_pkg::LSEG_ARMED:
				if (KEYSWITCH_VARIANT && !pin.interlock)
					next_rstate = lseg_pkg::LSEG_WAIT_RESET;
			default:
				next_rstate = lseg_pkg::LSEG_WAIT_RESET;
		endcase
	end

	// ready follows interlock directly on non-keyswitch units
	assign ready = (rstate == lseg_pkg::LSEG_ARMED) & pin.interlock;

	assign enable_cond = ready & gate_ok & pin.interlock & !inhibit;

	always_comb
	begin
		// restart on any drop so a glitch cannot shorten the wait
		if (!enable_cond)
			next_cnt = '0;
		else if (cnt != term)
			next_cnt = cnt + lseg_pkg::CNT_W'(1);
		else
			next_cnt = cnt;
	end

	assign delay_done = !KEYSWITCH_VARIANT || (cnt == term);
	assign rf_on      = enable_cond & delay_done;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rstate    <= lseg_pkg::LSEG_WAIT_RESET;
			cnt       <= '0;
			rst_prev  <= 1'b0;
			rf_prev   <= 1'b0;
			gate_prev <= 1'b0;
		end
		else
		begin
			rstate    <= next_rstate;
			cnt       <= next_cnt;
			rst_prev  <= next_rst_prev;
			rf_prev   <= rf_on;
			gate_prev <= gate_ok;
		end
	end

	// ****************************************
	// indicators and status outputs
	// ****************************************
	lseg_pkg::lseg_out_t next_ind;
	logic               next_gate_oe;
	logic               next_intlk_oe;

	always_comb
	begin
		next_ind.gate_indicator  = gate_ok & !inhibit;
		next_ind.ready_indicator = ready;
		next_ind.interlock_green = pin.interlock;
		next_ind.interlock_red   = !pin.interlock;
		next_ind.rf_power_en     = rf_on;
		next_gate_oe             = gate_ok;
		next_intlk_oe            = !pin.interlock;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ind             <= '0;
			gate_status_oe  <= 1'b0;
			intlk_status_oe <= 1'b0;
		end
		else
		begin
			ind             <= next_ind;
			gate_status_oe  <= next_gate_oe;
			intlk_status_oe <= next_intlk_oe;
		end
	end
	// open-collector: drive low when closed, release otherwise
	assign gate_status_out  = 1'b0;
	assign intlk_status_out = 1'b0;

	// ****************************************
	// apb slave, events and interrupt
	// ****************************************
	logic [lseg_pkg::EV_N-1:0] ev_stat;
	logic [lseg_pkg::EV_N-1:0] ev_mask;
	logic [lseg_pkg::EV_N-1:0] ev_set;
	logic [lseg_pkg::EV_N-1:0] next_ev_stat;
	logic [lseg_pkg::EV_N-1:0] next_ev_mask;
	logic                      next_sw_inhibit;
	logic                      next_irq;
	logic [31:0]               next_prdata;
	logic                      wr;
	logic                      rd;
	logic                      hit;

	assign wr      = psel & penable & pwrite;
	assign rd      = psel & !penable & !pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr == lseg_pkg::ADDR_CTRL) | (paddr == lseg_pkg::ADDR_STATUS)
		| (paddr == lseg_pkg::ADDR_EVENT) | (paddr == lseg_pkg::ADDR_MASK);
	assign pslverr = psel & penable & !hit;

	always_comb
	begin
		ev_set                       = '0;
		ev_set[lseg_pkg::EV_FAULT]   = ind.interlock_green & !pin.interlock;
		ev_set[lseg_pkg::EV_RF_ON]   = rf_on & !rf_prev;
		ev_set[lseg_pkg::EV_RF_OFF]  = !rf_on & rf_prev;
		ev_set[lseg_pkg::EV_GATE_DN] = !gate_ok & gate_prev;
		next_ev_stat    = ev_stat;
		next_ev_mask    = ev_mask;
		next_sw_inhibit = sw_inhibit;
		next_prdata     = prdata;
		if (wr && paddr == lseg_pkg::ADDR_CTRL)
			next_sw_inhibit = pwdata[lseg_pkg::CTRL_SW_INHIBIT];
		if (wr && paddr == lseg_pkg::ADDR_MASK)
			next_ev_mask = pwdata[lseg_pkg::EV_N-1:0];
		if (wr && paddr == lseg_pkg::ADDR_EVENT)
			next_ev_stat = ev_stat & ~pwdata[lseg_pkg::EV_N-1:0];
		// set wins over a clear in the same cycle
		next_ev_stat = next_ev_stat | ev_set;
		next_irq     = |(next_ev_stat & next_ev_mask);
		if (rd)
		begin
			next_prdata = '0;
			case (paddr)
				lseg_pkg::ADDR_CTRL:   next_prdata[lseg_pkg::CTRL_SW_INHIBIT] = sw_inhibit;
				lseg_pkg::ADDR_STATUS:
				begin
					next_prdata[lseg_pkg::ST_GATE]   = ind.gate_indicator;
					next_prdata[lseg_pkg::ST_READY]  = ready;
					next_prdata[lseg_pkg::ST_INTLK]  = pin.interlock;
					next_prdata[lseg_pkg::ST_RF]     = rf_on;
					next_prdata[lseg_pkg::ST_DELAY]  = enable_cond & !delay_done;
					next_prdata[lseg_pkg::ST_KEYVAR] = KEYSWITCH_VARIANT;
				end
				lseg_pkg::ADDR_EVENT:  next_prdata[lseg_pkg::EV_N-1:0] = ev_stat;
				lseg_pkg::ADDR_MASK:   next_prdata[lseg_pkg::EV_N-1:0] = ev_mask;
				default:               next_prdata = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ev_stat    <= '0;
			ev_mask    <= '0;
			sw_inhibit <= lseg_pkg::CTRL_RST_VAL[0];
			prdata     <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			ev_stat    <= next_ev_stat;
			ev_mask    <= next_ev_mask;
			sw_inhibit <= next_sw_inhibit;
			prdata     <= next_prdata;
			irq        <= next_irq;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	AST_GATE_NEEDS_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
		!gate_ok |-> ##1 !ind.rf_power_en) else $error("rf on without gate");
	AST_GATE_INDICATOR: assert property (@(posedge pclk) disable iff (!presetn)
		!pin.gate_switch_open |=> !ind.gate_indicator) else $error("indicator lit, switch closed");
	AST_GATE_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
		gate_ok |=> gate_status_oe) else $error("gate status not closed");
	AST_INTLK_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
		!pin.interlock |=> intlk_status_oe && ind.interlock_red) else $error("interlock status");
	AST_INTLK_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		!pin.interlock |=> !ind.rf_power_en && !ind.ready_indicator) else $error("interlock drop");
	AST_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
		inhibit |=> !ind.rf_power_en) else $error("rf on under inhibit");
	AST_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(enable_cond) && KEYSWITCH_VARIANT |-> !rf_on [*8]) else $error("delay skipped");
	AST_RF_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		ind.rf_power_en |-> ind.ready_indicator && ind.interlock_green && ind.gate_indicator)
		else $error("rf without cause");
	AST_NO_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		!KEYSWITCH_VARIANT && enable_cond |=> ind.rf_power_en) else $error("unwanted delay");
	AST_GATE_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
		gate_ok && !inhibit |=> ind.gate_indicator) else $error("indicator dark, gate open");
	AST_GATE_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
		!gate_ok |=> !gate_status_oe) else $error("gate status not released");
	AST_INTLK_CLOSED: assert property (@(posedge pclk) disable iff (!presetn)
		pin.interlock |=> !intlk_status_oe && ind.interlock_green)
		else $error("interlock healthy not shown");
	// a late rise would still pass here; only a rise less than 8 cycles after enable_cond is caught
	AST_RF_AFTER_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		KEYSWITCH_VARIANT && $rose(ind.rf_power_en) |-> $past(enable_cond, 8))
		else $error("rf rose early");
	AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		KEYSWITCH_VARIANT && $rose(ready) |-> $past(pin.remote_reset, 2))
		else $error("ready without reset pulse");
	// event flags are sticky: a set in the clearing cycle still lands
	AST_EV_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
		ind.interlock_green && !pin.interlock |=> ev_stat[lseg_pkg::EV_FAULT])
		else $error("fault event lost");
	AST_EV_RF_ON: assert property (@(posedge pclk) disable iff (!presetn)
		rf_on && !rf_prev |=> ev_stat[lseg_pkg::EV_RF_ON]) else $error("rf on event lost");
	AST_EV_GATE_DN: assert property (@(posedge pclk) disable iff (!presetn)
		!gate_ok && gate_prev |=> ev_stat[lseg_pkg::EV_GATE_DN]) else $error("gate event lost");
	AST_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && !hit |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ****************************************
	// covers
	// ****************************************
	CVR_RF_ON:   cover property (@(posedge pclk) disable iff (!presetn) $rose(rf_on));
	CVR_FAULT:   cover property (@(posedge pclk) disable iff (!presetn) rf_on ##1 !pin.interlock);
	CVR_INHIBIT: cover property (@(posedge pclk) disable iff (!presetn) enable_cond ##1 inhibit);
	CVR_ARMED:   cover property (@(posedge pclk) disable iff (!presetn) $rose(ready));
	CVR_GATE_DN: cover property (@(posedge pclk) disable iff (!presetn) rf_on ##1 !gate_ok);
endmodule : lseg_gating

// file: verification/lseg_plc.sv
// controller model that drives the gating pins and reads the status lines
`timescale 1ns/10ps
module lseg_plc
(
	input  wire logic               pclk,
	input  wire lseg_pkg::lseg_in_t want,
	input  wire logic               gate_status_out,
	input  wire logic               gate_status_oe,
	input  wire logic               intlk_status_out,
	input  wire logic               intlk_status_oe,
	output lseg_pkg::lseg_in_t      pins,
	output logic                    gate_line,
	output logic                    intlk_line
);
	// pulled-up lines: released reads high, never the last driven value
	assign gate_line  = gate_status_oe ? gate_status_out : 1'b1;
	assign intlk_line = intlk_status_oe ? intlk_status_out : 1'b1;
	initial pins = '0;
	always @(posedge pclk)
	begin
		pins.gate_switch_open <= want.gate_switch_open;
		pins.interlock        <= want.interlock;
		pins.remote_reset     <= want.remote_reset;
		// request lags the switch a cycle, so the order can never be reversed
		pins.gate_request     <= want.gate_request & pins.gate_switch_open;
	end
endmodule : lseg_plc

// file: verification/test_lseg_gating.sv
// self-checking bench for the laser safety enable gating block
`timescale 1ns/10ps
module test_lseg_gating;
	// ****************************************
	// signals
	// ****************************************
	typedef struct packed {
		logic        kind;
		logic [32:0] exp;
		logic [32:0] msk;
	} lseg_note_t;
	localparam int unsigned DLY = 20;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic [31:0]         pwdata = 32'h0000_0000;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	lseg_pkg::lseg_in_t  want = '0;
	lseg_pkg::lseg_in_t  pins;
	lseg_pkg::lseg_out_t ind;
	logic                gate_status_out;
	logic                gate_status_oe;
	logic                intlk_status_out;
	logic                intlk_status_oe;
	logic                irq;
	logic                gate_line;
	logic                intlk_line;
	logic [32:0]         bus_got;
	logic [32:0]         got;
	logic [31:0]         r;
	lseg_note_t          q[$];
	lseg_note_t          n;
	int                  n_fail = 0;
	int                  n_compared = 0;
	event                tick;

	// short delay count keeps the run brief; the waits for the delay derive from it
	lseg_gating #(.KEYSWITCH_VARIANT(1'b1), .DELAY_CYCLES(DLY)) i_lseg_gating
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins_in(pins), .ind(ind), .gate_status_out(gate_status_out),
		.gate_status_oe(gate_status_oe), .intlk_status_out(intlk_status_out),
		.intlk_status_oe(intlk_status_oe), .irq(irq)
	);
	lseg_plc i_lseg_plc
	(
		.pclk(pclk), .want(want), .gate_status_out(gate_status_out),
		.gate_status_oe(gate_status_oe), .intlk_status_out(intlk_status_out),
		.intlk_status_oe(intlk_status_oe), .pins(pins), .gate_line(gate_line),
		.intlk_line(intlk_line)
	);

	initial forever #5 pclk = ~pclk;

	// ****************************************
	// tasks
	// ****************************************
	task automatic conclude();
		// let the monitor take the last note before the queue is judged
		repeat (2) @(posedge pclk);
		if (q.size() != 0)
			n_fail++;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic note(input logic kind, input logic [32:0] exp, input logic [32:0] msk);
		q.push_back('{kind, exp, msk});
		->tick;
	endtask : note

	// lines read as closed = 1, so the view matches the status outputs
	task automatic look(input int cyc, input logic [7:0] exp, input logic [7:0] msk);
		repeat (cyc) @(posedge pclk);
		@(negedge pclk);
		note(1'b0, {25'h0, exp}, {25'h0, msk});
	endtask : look

	task automatic pin(input logic [3:0] w);
		@(posedge pclk);
		want <= w;
	endtask : pin

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 10; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		bus_got = {pslverr, prdata};
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i == 10)
		begin
			n_fail++;
			$display("ERROR %0t: no pready", $time);
			conclude();
		end
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [32:0] exp, input logic [32:0] msk);
		apb(1'b0, a, 32'h0000_0000);
		note(1'b1, exp, msk);
	endtask : rd

	// ****************************************
	// monitor
	// ****************************************
	always @(tick)
	begin
		n = q.pop_front();
		got = n.kind ? bus_got : {25'h0, ind, ~gate_line, ~intlk_line, irq};
		n_compared++;
		if ((got & n.msk) !== (n.exp & n.msk))
		begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got & n.msk, n.exp & n.msk);
		end
	end

	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		void'($urandom(70));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		look(5, 8'h12, 8'hFF);
		rd(12'h000, 33'h0, 33'h1_FFFF_FFFF);
		rd(12'h00C, 33'h0, 33'h1_FFFF_FFFF);
		rd(12'h004, 33'h20, 33'h20);
		rd(12'h010, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		r = $urandom & 32'h0000_000F;
		apb(1'b1, 12'h00C, r);
		rd(12'h00C, {1'b0, r}, 33'hF);
		apb(1'b1, 12'h00C, 32'h0000_000F);
		$display("registers done");
		pin(4'b0010);
		look(8, 8'h20, 8'h72);
		pin(4'b0011);
		look(8, 8'h00, 8'h08);
		pin(4'b0010);
		look(30, 8'h60, 8'h78);
		pin(4'b1110);
		look(12, 8'h04, 8'h0C);
		rd(12'h004, 33'h37, 33'h1_FFFF_FFFF);
		look(DLY, 8'h8D, 8'h8D);
		rd(12'h008, 33'h2, 33'h2);
		apb(1'b1, 12'h008, 32'h0000_000F);
		rd(12'h008, 33'h0, 33'h2);
		$display("gate open done");
		pin(4'b0110);
		look(8, 8'h01, 8'h8D);
		rd(12'h008, 33'hC, 33'hC);
		pin(4'b1110);
		look(DLY + 12, 8'h08, 8'h08);
		apb(1'b1, 12'h000, 32'h0000_0001);
		look(6, 8'h00, 8'h88);
		apb(1'b1, 12'h000, 32'h0000_0000);
		$display("inhibit done");
		pin(4'b1100);
		look(8, 8'h12, 8'h7A);
		rd(12'h008, 33'h1, 33'h1);
		pin(4'b1110);
		look(DLY + 12, 8'h20, 8'h68);
		$display("interlock done");
		conclude();
	end
endmodule : test_lseg_gating
